// >>> hw/dmcle_pkg.sv
// Shared constants and types for the mode/latency/self refresh command link
package dmcle_pkg;
	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int TMOD_NS       = 300;
	localparam int TMRD_NS       = 200;
	localparam logic [7:0] TMOD_CYC = 8'((TMOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] TMRD_CYC = 8'((TMRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [2:0] CAL_RESET  = 3'h0;
	localparam logic [1:0] SRT_RESET  = 2'h0;

	// ---------------------------------------------------------------
	// Commands and mode register fields
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		DMCLE_CMD_DES, DMCLE_CMD_MRS, DMCLE_CMD_REF, DMCLE_CMD_SRE,
		DMCLE_CMD_SRX, DMCLE_CMD_ACT, DMCLE_CMD_RD, DMCLE_CMD_WR
	} dmcle_cmd_t;

	localparam logic [1:0] MR_SEL_1 = 2'h1;
	localparam logic [1:0] MR_SEL_2 = 2'h2;
	localparam logic [1:0] MR_SEL_4 = 2'h0;
	localparam int MR1_WL_BIT  = 7;
	localparam int MR2_SRT_LO  = 6;
	localparam int MR4_CAL_LO  = 6;
	localparam logic [1:0] SRT_NORMAL  = 2'h0;
	localparam logic [1:0] SRT_EXTEND  = 2'h2;
	localparam logic [1:0] SRT_REDUCED = 2'h1;
	localparam logic [1:0] SRT_AUTO    = 2'h3;
	localparam logic [7:0] TEMP_HOT    = 8'h55;
	localparam logic [7:0] TEMP_COLD   = 8'h2D;
	localparam logic [1:0] RATE_LOW    = 2'h0;
	localparam logic [1:0] RATE_NORM   = 2'h1;
	localparam logic [1:0] RATE_HIGH   = 2'h2;

	// ---------------------------------------------------------------
	// Host register map
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_CMD    = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_CAL    = 4'h3;
	localparam int ST_BUSY = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_WL = 2;
	localparam int ST_SR = 3;
endpackage

// >>> hw/dmcle_if.sv
// Command/address link between controller and memory device
`timescale 1ns/100ps
`default_nettype none
interface dmcle_if;
	logic        cs_n;
	logic [2:0]  cmd;
	logic [1:0]  mr_sel;
	logic [15:0] addr;
	logic        odt;
	logic        dqs_o;
	logic        dqs_oe;
	logic        dq_o;
	logic        dq_oe;
	logic        dq_undef;

	modport ctrl (output cs_n, output cmd, output mr_sel, output addr, output odt,
		output dqs_o, output dqs_oe, input dq_o, input dq_oe, input dq_undef);
	modport dev (input cs_n, input cmd, input mr_sel, input addr, input odt,
		input dqs_o, input dqs_oe, output dq_o, output dq_oe, output dq_undef);
endinterface
`default_nettype wire

// >>> hw/dmcle_dev.sv
// Memory device end: CAL pipe, write leveling exit, self refresh mode
// How it works
// - Controller releases strobes after final edge
// - DQ undefined from release until tMOD
// - Controller holds ODT low during exit
// - Exit MRS only after termination off
// - Commands after tMOD, MRS after tMRD
// - Exit MRS writes MR1 bit 7 zero
// - CAL cycles between CS low and command
// - CAL count programmed by MRS, rounded up
// - Receivers off after latch, CS high
// - Receivers stay on through consecutive commands
// - Non-MRS waits tMOD plus tCAL
// - MRS to MRS waits tMOD plus tCAL
// - Waits use the new CAL value
// - ODT timing unaffected by CAL
// - MR2 bits 7:6 = 11 selects auto
// - Auto rate follows temperature
// - Manual modes 00, 10, 01
// - Manual mode latched at entry, held
// - Mode changes only outside self refresh
`timescale 1ns/100ps
`default_nettype none
module dmcle_dev (
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	dmcle_if.dev             link,
	input  wire logic [7:0]  temp_i,
	output logic             rx_en_o,
	output logic             odt_on_o,
	output logic [1:0]       sr_rate_o,
	output logic             in_sr_o,
	output logic             wl_mode_o,
	output logic [1:0]       srt_mode_o,
	output logic [2:0]       cal_o
);
	import dmcle_pkg::*;

	logic [7:0]  cs_pipe;
	logic [2:0]  cal;
	logic [1:0]  srt;
	logic [1:0]  srt_held;
	logic        wl;
	logic [7:0]  undef_cnt;
	logic        undef;
	logic        cmd_hit;
	logic [7:0]  temp_s1;
	logic [7:0]  temp_s2;
	logic        dqs_prev;
	logic [7:0]  cal_mask;

	// ---------------------------------------------------------------
	// CAL pipe: command taken CAL cycles after CS low
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cs_pipe <= 8'h00;
		end else begin
			cs_pipe <= {cs_pipe[6:0], ~link.cs_n};
		end
	end

	always_comb begin
		if (cal == 3'h0) begin
			cmd_hit = ~link.cs_n;
		end else begin
			cmd_hit = cs_pipe[cal - 3'h1];
		end
	end

	// Only CS lows still inside the latency window keep receivers awake
	assign cal_mask = 8'hFF >> (4'h8 - {1'b0, cal});

	// Receivers on from CS low until last pending command is latched
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_en_o <= 1'b1;
		end else if (cal == 3'h0) begin
			rx_en_o <= 1'b1;
		end else begin
			rx_en_o <= ~link.cs_n | (|(cs_pipe & cal_mask));
		end
	end

	// ODT sampled directly, never through the CAL pipe
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			odt_on_o <= 1'b0;
		end else begin
			odt_on_o <= link.odt;
		end
	end

	// ---------------------------------------------------------------
	// Mode register decode
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cal <= CAL_RESET;
			wl  <= 1'b0;
			srt <= SRT_RESET;
		end else if (cmd_hit && dmcle_cmd_t'(link.cmd) == DMCLE_CMD_MRS) begin
			unique case (link.mr_sel)
				MR_SEL_1: wl <= link.addr[MR1_WL_BIT];
				MR_SEL_2: srt <= link.addr[MR2_SRT_LO +: 2];
				MR_SEL_4: cal <= link.addr[MR4_CAL_LO +: 3];
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Write leveling exit: DQ undefined until tMOD after exit MRS
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			undef     <= 1'b0;
			undef_cnt <= 8'h00;
			dqs_prev  <= 1'b0;
		end else begin
			dqs_prev <= link.dqs_oe;
			if (wl && dqs_prev && !link.dqs_oe) begin
				undef <= 1'b1;
			end
			if (wl && cmd_hit && dmcle_cmd_t'(link.cmd) == DMCLE_CMD_MRS
					&& link.mr_sel == MR_SEL_1 && !link.addr[MR1_WL_BIT]) begin
				undef     <= 1'b1;
				undef_cnt <= TMOD_CYC;
			end else if (undef_cnt != 8'h00) begin
				undef_cnt <= undef_cnt - 8'h01;
				if (undef_cnt == 8'h01) begin
					undef <= 1'b0;
				end
			end
		end
	end

	// Feedback: strobe captures state of its own rising edge
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			link.dq_o  <= 1'b0;
			link.dq_oe <= 1'b0;
		end else begin
			link.dq_oe <= wl | undef;
			if (wl && !undef && link.dqs_oe) begin
				link.dq_o <= link.dqs_o;
			end else if (!wl && !undef) begin
				// Released pin reads low, not a stale feedback bit
				link.dq_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			link.dq_undef <= 1'b0;
		end else begin
			link.dq_undef <= undef;
		end
	end

	// ---------------------------------------------------------------
	// Self refresh: mode latched at entry, rate from temperature
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			temp_s1 <= 8'h00;
			temp_s2 <= 8'h00;
		end else begin
			temp_s1 <= temp_i;
			temp_s2 <= temp_s1;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			in_sr_o  <= 1'b0;
			srt_held <= SRT_RESET;
		end else if (cmd_hit && dmcle_cmd_t'(link.cmd) == DMCLE_CMD_SRE) begin
			in_sr_o  <= 1'b1;
			srt_held <= srt;
		end else if (cmd_hit && dmcle_cmd_t'(link.cmd) == DMCLE_CMD_SRX) begin
			in_sr_o <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sr_rate_o <= RATE_NORM;
		end else begin
			unique case (srt_held)
				SRT_AUTO: begin
					if (temp_s2 >= TEMP_HOT) begin
						sr_rate_o <= RATE_HIGH;
					end else if (temp_s2 <= TEMP_COLD) begin
						sr_rate_o <= RATE_LOW;
					end else begin
						sr_rate_o <= RATE_NORM;
					end
				end
				SRT_EXTEND:  sr_rate_o <= RATE_HIGH;
				SRT_REDUCED: sr_rate_o <= RATE_LOW;
				SRT_NORMAL:  sr_rate_o <= RATE_NORM;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wl_mode_o  <= 1'b0;
			srt_mode_o <= SRT_RESET;
			cal_o      <= CAL_RESET;
		end else begin
			wl_mode_o  <= wl;
			srt_mode_o <= srt;
			cal_o      <= cal;
		end
	end
endmodule
`default_nettype wire

// >>> hw/dmcle_ctrl.sv
// Controller end: issues commands with CAL and post-MRS spacing
`timescale 1ns/100ps
`default_nettype none
module dmcle_ctrl (
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	dmcle_if.ctrl            link,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic [15:0]      rdata_o
);
	import dmcle_pkg::*;

	typedef enum {DMCLE_IDLE, DMCLE_WAITCA, DMCLE_GAP} dmcle_state_t;
	dmcle_state_t state;

	logic [15:0] cmd_word;
	logic [15:0] addr_word;
	logic [2:0]  cal;
	logic [2:0]  cal_cnt;
	logic [7:0]  mrs_wait;
	logic [7:0]  cmd_wait;
	logic        wl;
	logic        in_sr;
	logic        refused;
	logic        go;
	logic [2:0]  req_cmd;
	logic [1:0]  req_sel;
	logic        req_is_mrs;
	logic        blocked;
	logic [2:0]  new_cal;
	logic        wl_exit;
	logic        srt_write;
	logic        hold_off;
	logic        fire;

	assign req_cmd    = cmd_word[2:0];
	assign req_sel    = cmd_word[5:4];
	assign req_is_mrs = dmcle_cmd_t'(req_cmd) == DMCLE_CMD_MRS;
	assign new_cal    = (req_is_mrs && req_sel == MR_SEL_4) ? addr_word[MR4_CAL_LO +: 3] : cal;
	assign wl_exit    = req_is_mrs && req_sel == MR_SEL_1 && !addr_word[MR1_WL_BIT];
	assign srt_write  = req_is_mrs && req_sel == MR_SEL_2;
	// Self refresh mode may not change inside self refresh; exit MRS is refused while ODT is high
	assign blocked    = (srt_write && in_sr) || (wl_exit && link.odt);
	assign hold_off   = blocked || (req_is_mrs ? mrs_wait != 8'h00 : cmd_wait != 8'h00);
	// Command goes out CAL cycles after the CS low, so the device pipe meets it
	assign fire       = (state == DMCLE_IDLE && go && !hold_off && cal == 3'h0)
		|| (state == DMCLE_WAITCA && cal_cnt == 3'h1);

	// ---------------------------------------------------------------
	// Register port
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cmd_word  <= 16'h0000;
			addr_word <= 16'h0000;
			go        <= 1'b0;
			link.odt  <= 1'b0;
			link.dqs_o  <= 1'b0;
			link.dqs_oe <= 1'b0;
		end else begin
			go <= 1'b0;
			if (wr_i && addr_i == REG_CMD) begin
				cmd_word <= wdata_i;
				go       <= 1'b1;
				link.odt <= wdata_i[8];
				link.dqs_oe <= wdata_i[9];
				link.dqs_o  <= wdata_i[10];
			end
			if (wr_i && addr_i == REG_ADDR) begin
				addr_word <= wdata_i;
			end
			if (go && wl_exit) begin
				link.odt    <= 1'b0;
				link.dqs_oe <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 16'h0000;
		end else if (rd_i) begin
			unique case (addr_i)
				REG_CMD:    rdata_o <= cmd_word;
				REG_ADDR:   rdata_o <= addr_word;
				REG_STATUS: rdata_o <= {12'h000, in_sr, wl, refused, state != DMCLE_IDLE};
				REG_CAL:    rdata_o <= {link.dq_undef, link.dq_oe, link.dq_o, 10'h000, cal};
				default:    rdata_o <= 16'h0000;
			endcase
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	// ---------------------------------------------------------------
	// Command sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state     <= DMCLE_IDLE;
			link.cs_n <= 1'b1;
			link.cmd  <= 3'h0;
			link.mr_sel <= 2'h0;
			link.addr <= 16'h0000;
			cal_cnt   <= 3'h0;
			cal       <= CAL_RESET;
			wl        <= 1'b0;
			in_sr     <= 1'b0;
			refused   <= 1'b0;
			mrs_wait  <= 8'h00;
			cmd_wait  <= 8'h00;
		end else begin
			if (mrs_wait != 8'h00) mrs_wait <= mrs_wait - 8'h01;
			if (cmd_wait != 8'h00) cmd_wait <= cmd_wait - 8'h01;
			unique case (state)
				DMCLE_IDLE: begin
					if (go) begin
						if (hold_off) begin
							refused <= 1'b1;
						end else begin
							refused   <= 1'b0;
							link.cs_n <= 1'b0;
							cal_cnt   <= cal;
							state     <= DMCLE_WAITCA;
						end
					end
				end
				DMCLE_WAITCA: begin
					link.cs_n <= 1'b1;
					cal_cnt   <= cal_cnt - 3'h1;
				end
				DMCLE_GAP: begin
					link.cs_n <= 1'b1;
					link.cmd  <= 3'h0;
					state     <= DMCLE_IDLE;
				end
			endcase
			// With CAL nonzero CS stays high beside the command, else the device sees a second select
			if (fire) begin
				link.cmd    <= req_cmd;
				link.mr_sel <= req_sel;
				link.addr   <= addr_word;
				state       <= DMCLE_GAP;
				if (req_is_mrs) begin
						cal <= new_cal;
						if (req_sel == MR_SEL_1) wl <= addr_word[MR1_WL_BIT];
						if (new_cal != 3'h0 || cal != 3'h0) begin
							mrs_wait <= TMOD_CYC + {5'h00, new_cal};
						end else begin
							mrs_wait <= TMRD_CYC;
						end
						cmd_wait <= TMOD_CYC + {5'h00, new_cal};
					end
					if (dmcle_cmd_t'(req_cmd) == DMCLE_CMD_SRE) in_sr <= 1'b1;
					if (dmcle_cmd_t'(req_cmd) == DMCLE_CMD_SRX) in_sr <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/dmcle_asserts.sv
// Concurrent checks on the controller/device link
`timescale 1ns/100ps
`default_nettype none
module dmcle_asserts (
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	input  wire logic        cs_n,
	input  wire logic [2:0]  cmd,
	input  wire logic [1:0]  mr_sel,
	input  wire logic [15:0] addr,
	input  wire logic        odt,
	input  wire logic        dqs_oe,
	input  wire logic        dq_undef,
	input  wire logic        odt_on
);
	import dmcle_pkg::*;
	logic wl_exit;
	// ---------------------------------------------------------------
	// Link properties
	// ---------------------------------------------------------------
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);
	assign wl_exit = cmd == DMCLE_CMD_MRS && mr_sel == MR_SEL_1 && !addr[MR1_WL_BIT];
	cs_len_a: assert property (!cs_n ##1 !cs_n |=> cs_n)
		else $error("chip select held low too long");
	exit_odt_a: assert property (wl_exit |-> !odt)
		else $error("leveling exit sent with termination on");
	exit_dqs_a: assert property (wl_exit |-> !dqs_oe)
		else $error("strobe still driven at leveling exit");
	undef_dqs_a: assert property (dq_undef |-> !dqs_oe)
		else $error("data undefined while strobe driven");
	undef_min_a: assert property ($rose(dq_undef) |-> dq_undef[*6])
		else $error("data undefined window too short");
	undef_end_a: assert property ($rose(dq_undef) |-> ##[6:40] !dq_undef)
		else $error("data undefined window never ends");
	odt_align_a: assert property (odt_on == $past(odt))
		else $error("termination moved apart from command");
	mrs_gap_a: assert property ($rose(cmd == DMCLE_CMD_MRS) |=>
		(cmd == DMCLE_CMD_MRS || cmd == DMCLE_CMD_DES)[*5])
		else $error("command too soon after mode write");
endmodule
`default_nettype wire

// >>> bench/dmcle_tb.sv
// Self-checking bench for the controller/device link
`timescale 1ns/100ps
`default_nettype none
module dmcle_tb;
	import dmcle_pkg::*;
	logic        clock_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [3:0]  addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [7:0]  temp_i = 8'h10;
	logic [15:0] rdata_o;
	logic        rx_en_o, odt_on_o, in_sr_o, wl_mode_o;
	logic [1:0]  sr_rate_o, srt_mode_o;
	logic [2:0]  cal_o;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cycles = 0;
	logic [15:0] v;

	always #25 clock_i = ~clock_i;
	dmcle_if dmcle_if_inst ();
	dmcle_ctrl dmcle_ctrl_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(dmcle_if_inst),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
	dmcle_dev dmcle_dev_inst (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(dmcle_if_inst),
		.temp_i(temp_i), .rx_en_o(rx_en_o), .odt_on_o(odt_on_o), .sr_rate_o(sr_rate_o),
		.in_sr_o(in_sr_o), .wl_mode_o(wl_mode_o), .srt_mode_o(srt_mode_o), .cal_o(cal_o));
	dmcle_asserts dmcle_asserts_inst (.clock_i(clock_i), .reset_n_i(reset_n_i),
		.cs_n(dmcle_if_inst.cs_n), .cmd(dmcle_if_inst.cmd), .mr_sel(dmcle_if_inst.mr_sel),
		.addr(dmcle_if_inst.addr), .odt(dmcle_if_inst.odt), .dqs_oe(dmcle_if_inst.dqs_oe),
		.dq_undef(dmcle_if_inst.dq_undef), .odt_on(odt_on_o));

	// ---------------------------------------------------------------
	// Bus tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic issue(input dmcle_cmd_t c, input logic [1:0] ms, input logic [15:0] a,
		input logic o, input logic s);
		wr(REG_ADDR, a);
		wr(REG_CMD, {5'h0, s, s, o, 2'h0, ms, 1'b0, c});
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		check(16'(dmcle_if_inst.cs_n), 16'h1);
		check(16'(rx_en_o), 16'h1);
		check(16'(sr_rate_o), 16'(RATE_NORM));
		rd(REG_CAL);
		check(v, 16'(CAL_RESET));
	endtask
	task automatic t_wl;
		issue(DMCLE_CMD_MRS, MR_SEL_1, 16'h0080, 1'b0, 1'b1);
		idle(12);
		check(16'(wl_mode_o), 16'h1);
		rd(REG_CAL);
		check(v, 16'h6000);
		issue(DMCLE_CMD_MRS, MR_SEL_1, 16'h0000, 1'b1, 1'b1);
		idle(12);
		check(16'(wl_mode_o), 16'h1);
		rd(REG_STATUS);
		check(16'(v[ST_REFUSED]), 16'h1);
		issue(DMCLE_CMD_MRS, MR_SEL_1, 16'h0000, 1'b0, 1'b0);
		// Self refresh entry lands inside the post-exit wait
		idle(1);
		issue(DMCLE_CMD_SRE, 2'h0, 16'h0, 1'b0, 1'b0);
		idle(2);
		check(16'(dmcle_if_inst.dq_undef), 16'h1);
		idle(12);
		check(16'(in_sr_o), 16'h0);
		check(16'(wl_mode_o), 16'h0);
		check(16'(dmcle_if_inst.dq_undef), 16'h0);
	endtask
	task automatic t_cal;
		int n;
		issue(DMCLE_CMD_MRS, MR_SEL_4, 16'h00C0, 1'b0, 1'b0);
		// Past the plain mode gap but short of the latency-stretched one
		idle(4);
		issue(DMCLE_CMD_MRS, MR_SEL_2, {8'h0, SRT_EXTEND, 6'h0}, 1'b0, 1'b0);
		idle(14);
		check(16'(cal_o), 16'h3);
		check(16'(srt_mode_o), 16'(SRT_NORMAL));
		rd(REG_CAL);
		check(v, 16'h3);
		issue(DMCLE_CMD_RD, 2'h0, 16'h0, 1'b1, 1'b0);
		for (n = 0; n < 6 && dmcle_if_inst.cs_n !== 1'b0; n++)
			idle(1);
		check(16'(dmcle_if_inst.cmd == DMCLE_CMD_RD), 16'h0);
		idle(3);
		check(16'(dmcle_if_inst.cmd), 16'(DMCLE_CMD_RD));
		check(16'(dmcle_if_inst.cs_n), 16'h1);
		check(16'(rx_en_o), 16'h1);
		idle(2);
		check(16'(odt_on_o), 16'h1);
		check(16'(rx_en_o), 16'h0);
		idle(10);
		issue(DMCLE_CMD_MRS, MR_SEL_4, 16'h0000, 1'b0, 1'b0);
		idle(14);
		check(16'(cal_o), 16'h0);
	endtask
	task automatic t_srt;
		logic [1:0] mode [4] = '{SRT_NORMAL, SRT_EXTEND, SRT_REDUCED, SRT_AUTO};
		logic [1:0] rate [4] = '{RATE_NORM, RATE_HIGH, RATE_LOW, RATE_LOW};
		for (int i = 0; i < 4; i++) begin
			issue(DMCLE_CMD_MRS, MR_SEL_2, {8'h0, mode[i], 6'h0}, 1'b0, 1'b0);
			idle(12);
			check(16'(srt_mode_o), 16'(mode[i]));
			issue(DMCLE_CMD_SRE, 2'h0, 16'h0, 1'b0, 1'b0);
			idle(8);
			check(16'(in_sr_o), 16'h1);
			check(16'(sr_rate_o), 16'(rate[i]));
			issue(DMCLE_CMD_MRS, MR_SEL_2, {8'h0, ~mode[i], 6'h0}, 1'b0, 1'b0);
			temp_i <= 8'h70;
			idle(12);
			check(16'(srt_mode_o), 16'(mode[i]));
			check(16'(sr_rate_o), 16'(i == 3 ? RATE_HIGH : rate[i]));
			issue(DMCLE_CMD_SRX, 2'h0, 16'h0, 1'b0, 1'b0);
			temp_i <= 8'h10;
			idle(12);
			check(16'(in_sr_o), 16'h0);
		end
	endtask

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			conclude();
		end
	end
	initial begin
		repeat (3) @(posedge clock_i);
		reset_n_i <= 1'b1;
		idle(1);
		t_reset();
		t_wl();
		t_cal();
		t_srt();
		conclude();
	end
endmodule
`default_nettype wire
